// File: common/ecct_params.svh
// Constants of the error trap and command decode block
`ifndef ECCT_PARAMS_SVH
`define ECCT_PARAMS_SVH
`define ECCT_OP_STATUS_READ  8'h19
`define ECCT_OP_CLEAR        8'h1b
`define ECCT_OP_CKSUM_RUN    8'h5b
`define ECCT_OP_CKSUM_PAUSE  8'h75
`define ECCT_OP_CKSUM_CONT   8'h7a
`define ECCT_OPCODE_LAST     5'h07
`define ECCT_ADDR_LAST       5'h17
`define ECCT_DATA_LAST       5'h07
`define ECCT_UNIT_LSB        3
`define ECCT_ADDR_RESET      32'h00000000
`define ECCT_CNT_RESET       16'h0000
`define ECCT_CNT_MAX         16'hffff
`define ECCT_CNT_ONE         16'h0001
`define ECCT_FLAG_BIT        4
`define ECCT_UNIT_ERR_BIT    3
`define ECCT_EV_CLEAR        0
`define ECCT_EV_RUN          1
`define ECCT_EV_PAUSE        2
`define ECCT_EV_CONT         3
`define ECCT_EV_QUERY        4
`endif

// File: common/ecct_pkg.sv
// Types of the error trap and command decode block
package ecct_pkg;
	typedef enum logic [2:0] {
		ECCT_OPCODE,
		ECCT_ADDR,
		ECCT_DUMMY,
		ECCT_DATA,
		ECCT_DONE
	} ecct_phase_type;

	typedef struct packed {
		logic        hit;
		logic [23:0] addr;
	} ecct_err_type;

	typedef struct packed {
		logic        pause;
		logic        cont;
		logic        run;
	} ecct_cksum_type;
endpackage

// File: hw/ecct_trap.sv
// Error address trap, detection counter and serial command decode
`timescale 1ns/1ps
`include "ecct_params.svh"
module ecct_trap
	import ecct_pkg::*;
(
	input  wire logic           CLK,
	input  wire logic           SYS_RST,
	input  wire ecct_err_type   ECC_ERR,
	input  wire logic           DEEP_SLEEP,
	input  wire logic [3:0]     MEMORY_LATENCY_FIELD,
	input  wire logic           SCK,
	input  wire logic           CS_N,
	input  wire logic           SI,
	output logic                SO,
	output logic                SO_OE,
	output logic [31:0]         FIRST_ERROR_UNIT_ADDRESS,
	output logic [15:0]         ERROR_DETECT_COUNTER,
	output logic [7:0]          ERROR_STATUS_REGISTER,
	output logic                UNIT_QUERY_REQ,
	output logic [23:0]         UNIT_QUERY_ADDR,
	input  wire logic           UNIT_QUERY_ERR,
	output ecct_cksum_type      CKSUM_CMD
);

	function automatic logic [23:0] unit_align(input logic [23:0] a);
		unit_align = {a[23:`ECCT_UNIT_LSB], {`ECCT_UNIT_LSB{1'b0}}};
	endfunction

	function automatic logic [15:0] sat_inc(input logic [15:0] c);
		sat_inc = (c == `ECCT_CNT_MAX) ? c : c + `ECCT_CNT_ONE;
	endfunction

	// Serial link domain
	ecct_phase_type phase_ff;
	ecct_phase_type nxt_phase;
	logic [4:0]     cnt_ff;
	logic [4:0]     nxt_cnt;
	logic [22:0]    sh_in_ff;
	logic [23:0]    q_addr_ff;
	logic [7:0]     out_sh_ff;
	logic [7:0]     nxt_out_sh;
	logic [4:0]     ev_tgl_ff;
	logic [4:0]     nxt_ev_tgl;
	logic [3:0]     lat_s1_ff;
	logic [3:0]     lat_s2_ff;
	logic           ack_s1_ff;
	logic           ack_s2_ff;
	logic           so_ff;
	logic           ack_ff;
	logic           res_ff;

	wire [7:0]  opcode     = {sh_in_ff[6:0], SI};
	wire [23:0] addr_word  = {sh_in_ff, SI};
	wire        op_done    = (phase_ff == ECCT_OPCODE) && (cnt_ff == `ECCT_OPCODE_LAST);
	wire        addr_done  = (phase_ff == ECCT_ADDR) && (cnt_ff == `ECCT_ADDR_LAST);
	wire        dummy_none = (lat_s2_ff == 4'h0);
	wire        dummy_done = (phase_ff == ECCT_DUMMY) && (cnt_ff[3:0] == lat_s2_ff - 4'h1);
	wire        data_done  = (phase_ff == ECCT_DATA) && (cnt_ff == `ECCT_DATA_LAST);
	wire        ans_ready  = (ack_s2_ff == ev_tgl_ff[`ECCT_EV_QUERY]);
	wire        res_bit    = ans_ready & res_ff;
	wire [7:0]  status_byte = {7'h00, res_bit} << `ECCT_UNIT_ERR_BIT;
	wire        load_out   = dummy_done || (addr_done && dummy_none);

	always_comb
	begin
		nxt_phase  = phase_ff;
		nxt_cnt    = cnt_ff + 5'h01;
		nxt_ev_tgl = ev_tgl_ff;
		nxt_out_sh = {out_sh_ff[6:0], 1'b0};
		if (op_done)
		begin
			nxt_cnt   = 5'h00;
			nxt_phase = ECCT_DONE;
			case (opcode)
				`ECCT_OP_STATUS_READ: nxt_phase = ECCT_ADDR;
				`ECCT_OP_CLEAR:       nxt_ev_tgl[`ECCT_EV_CLEAR] = ~ev_tgl_ff[`ECCT_EV_CLEAR];
				`ECCT_OP_CKSUM_RUN:   nxt_ev_tgl[`ECCT_EV_RUN] = ~ev_tgl_ff[`ECCT_EV_RUN];
				`ECCT_OP_CKSUM_PAUSE: nxt_ev_tgl[`ECCT_EV_PAUSE] = ~ev_tgl_ff[`ECCT_EV_PAUSE];
				`ECCT_OP_CKSUM_CONT:  nxt_ev_tgl[`ECCT_EV_CONT] = ~ev_tgl_ff[`ECCT_EV_CONT];
				default:              nxt_phase = ECCT_DONE;
			endcase
		end
		else if (addr_done)
		begin
			nxt_cnt = 5'h00;
			nxt_ev_tgl[`ECCT_EV_QUERY] = ~ev_tgl_ff[`ECCT_EV_QUERY];
			nxt_phase = dummy_none ? ECCT_DATA : ECCT_DUMMY;
		end
		else if (dummy_done)
		begin
			nxt_cnt   = 5'h00;
			nxt_phase = ECCT_DATA;
		end
		else if (data_done)
		begin
			nxt_cnt   = 5'h00;
			nxt_phase = ECCT_DONE;
		end
		else if (phase_ff == ECCT_DONE)
			nxt_cnt = 5'h00;
		if (load_out)
			nxt_out_sh = status_byte;
	end

	// Frame state ends with chip select
	always_ff @(posedge SCK or posedge CS_N)
	begin
		if (CS_N)
		begin
			phase_ff  <= ECCT_OPCODE;
			cnt_ff    <= 5'h00;
			out_sh_ff <= 8'h00;
		end
		else
		begin
			phase_ff  <= nxt_phase;
			cnt_ff    <= nxt_cnt;
			out_sh_ff <= nxt_out_sh;
		end
	end

	always_ff @(posedge SCK)
	begin
		sh_in_ff  <= {sh_in_ff[21:0], SI};
		lat_s1_ff <= MEMORY_LATENCY_FIELD;
		lat_s2_ff <= lat_s1_ff;
		ack_s1_ff <= ack_ff;
		ack_s2_ff <= ack_s1_ff;
		if (addr_done)
			q_addr_ff <= unit_align(addr_word);
	end

	// Event toggles survive frames
	always_ff @(posedge SCK or posedge SYS_RST)
	begin
		if (SYS_RST)
			ev_tgl_ff <= 5'h00;
		else
			ev_tgl_ff <= nxt_ev_tgl;
	end

	// Output changes on falling edge
	always_ff @(negedge SCK or posedge CS_N)
	begin
		if (CS_N)
			so_ff <= 1'b0;
		else
			so_ff <= (phase_ff == ECCT_DATA) ? out_sh_ff[7] : 1'b0;
	end

	assign SO    = so_ff;
	assign SO_OE = ~CS_N && (phase_ff == ECCT_DATA);

	// System clock domain
	logic [4:0]  ev_s1_ff;
	logic [4:0]  ev_s2_ff;
	logic [4:0]  ev_s3_ff;
	logic        req_ff;
	logic        req_d_ff;
	logic [23:0] uq_addr_ff;
	logic        flag_ff;
	logic [31:0] trap_ff;
	logic [15:0] cnt16_ff;
	logic [2:0]  cks_ff;
	logic        nxt_flag;
	logic [31:0] nxt_trap;
	logic [15:0] nxt_cnt16;

	wire [4:0] ev_pulse  = ev_s2_ff ^ ev_s3_ff;
	wire       clear_evt = ev_pulse[`ECCT_EV_CLEAR];
	wire       hit       = ECC_ERR.hit;

	always_comb
	begin
		nxt_flag  = flag_ff;
		nxt_trap  = trap_ff;
		nxt_cnt16 = cnt16_ff;
		if (clear_evt || DEEP_SLEEP)
		begin
			nxt_flag  = 1'b0;
			nxt_trap  = `ECCT_ADDR_RESET;
			nxt_cnt16 = `ECCT_CNT_RESET;
		end
		if (hit && !DEEP_SLEEP)
		begin
			nxt_flag  = 1'b1;
			nxt_cnt16 = sat_inc(nxt_cnt16);
			if (!flag_ff || clear_evt)
				nxt_trap = {8'h00, unit_align(ECC_ERR.addr)};
		end
	end

	always_ff @(posedge CLK)
	begin
		ev_s1_ff <= ev_tgl_ff;
		ev_s2_ff <= ev_s1_ff;
		if (SYS_RST)
		begin
			ev_s3_ff   <= 5'h00;
			flag_ff    <= 1'b0;
			trap_ff    <= `ECCT_ADDR_RESET;
			cnt16_ff   <= `ECCT_CNT_RESET;
			ack_ff     <= 1'b0;
			req_ff     <= 1'b0;
			req_d_ff   <= 1'b0;
			res_ff     <= 1'b0;
			uq_addr_ff <= 24'h000000;
			cks_ff     <= 3'h0;
		end
		else
		begin
			ev_s3_ff <= ev_s2_ff;
			flag_ff  <= nxt_flag;
			trap_ff  <= nxt_trap;
			cnt16_ff <= nxt_cnt16;
			req_ff   <= ev_pulse[`ECCT_EV_QUERY];
			req_d_ff <= req_ff;
			if (ev_pulse[`ECCT_EV_QUERY])
				uq_addr_ff <= q_addr_ff;
			if (req_d_ff)
			begin
				res_ff <= UNIT_QUERY_ERR;
				ack_ff <= ~ack_ff;
			end
			cks_ff <= {ev_pulse[`ECCT_EV_PAUSE], ev_pulse[`ECCT_EV_CONT],
				ev_pulse[`ECCT_EV_RUN]};
		end
	end

	// Visible to the register read path
	assign FIRST_ERROR_UNIT_ADDRESS = trap_ff;
	assign ERROR_DETECT_COUNTER     = cnt16_ff;
	assign ERROR_STATUS_REGISTER    = {7'h00, flag_ff} << `ECCT_FLAG_BIT;
	assign UNIT_QUERY_REQ           = req_ff;
	assign UNIT_QUERY_ADDR          = uq_addr_ff;
	assign CKSUM_CMD                = cks_ff;

	property p_first_capture;
		@(posedge CLK) disable iff (SYS_RST)
		(hit && !flag_ff && !DEEP_SLEEP) |=> (trap_ff == {8'h00, unit_align($past(ECC_ERR.addr))});
	endproperty
	a_first_capture: assert property (p_first_capture) else $error("first address lost");

	property p_later_hold;
		@(posedge CLK) disable iff (SYS_RST)
		(hit && flag_ff && !clear_evt && !DEEP_SLEEP) |=> $stable(trap_ff) && flag_ff;
	endproperty
	a_later_hold: assert property (p_later_hold) else $error("trap overwritten");

	property p_count_up;
		@(posedge CLK) disable iff (SYS_RST)
		(hit && !clear_evt && !DEEP_SLEEP && cnt16_ff != `ECCT_CNT_MAX)
		|=> cnt16_ff == $past(cnt16_ff) + `ECCT_CNT_ONE;
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter missed step");

	property p_count_sat;
		@(posedge CLK) disable iff (SYS_RST)
		(cnt16_ff == `ECCT_CNT_MAX && !clear_evt && !DEEP_SLEEP) |=> cnt16_ff == `ECCT_CNT_MAX;
	endproperty
	a_count_sat: assert property (p_count_sat) else $error("counter wrapped");

	property p_clear_all;
		@(posedge CLK) disable iff (SYS_RST)
		(clear_evt && !hit) |=> (trap_ff == `ECCT_ADDR_RESET) && !flag_ff && cnt16_ff == 16'h0000;
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("clear incomplete");

	property p_sleep_zero;
		@(posedge CLK) disable iff (SYS_RST)
		DEEP_SLEEP |=> (trap_ff == `ECCT_ADDR_RESET) ##1 (trap_ff == `ECCT_ADDR_RESET) || $past(!DEEP_SLEEP);
	endproperty
	a_sleep_zero: assert property (p_sleep_zero) else $error("trap kept in sleep");

	property p_aligned;
		@(posedge CLK) disable iff (SYS_RST)
		(trap_ff[2:0] == 3'h0) && (trap_ff[31:24] == 8'h00);
	endproperty
	a_aligned: assert property (p_aligned) else $error("trap not unit aligned");

	property p_flag_tracks;
		@(posedge CLK) disable iff (SYS_RST)
		$rose(flag_ff) |-> $past(hit) && ERROR_STATUS_REGISTER == 8'h10;
	endproperty
	a_flag_tracks: assert property (p_flag_tracks) else $error("flag without error");

	property p_query_req;
		@(posedge CLK) disable iff (SYS_RST)
		ev_pulse[`ECCT_EV_QUERY] |=> UNIT_QUERY_REQ ##1 !UNIT_QUERY_REQ ##1 (ack_ff != $past(ack_ff, 2));
	endproperty
	a_query_req: assert property (p_query_req) else $error("query not served");

	property p_status_form;
		@(posedge SCK) disable iff (CS_N)
		load_out |=> (out_sh_ff[7:4] == 4'h0) && (out_sh_ff[2:0] == 3'h0) && phase_ff == ECCT_DATA;
	endproperty
	a_status_form: assert property (p_status_form) else $error("bad status byte");

	property p_clear_decode;
		@(posedge SCK) disable iff (CS_N || SYS_RST)
		(op_done && opcode == `ECCT_OP_CLEAR) |-> nxt_ev_tgl[`ECCT_EV_CLEAR] != ev_tgl_ff[`ECCT_EV_CLEAR];
	endproperty
	a_clear_decode: assert property (p_clear_decode) else $error("clear not decoded");

	property p_cksum_pulse;
		@(posedge CLK) disable iff (SYS_RST)
		(cks_ff != 3'h0) |=> (cks_ff == 3'h0);
	endproperty
	a_cksum_pulse: assert property (p_cksum_pulse) else $error("checksum pulse too long");

	property p_cksum_one;
		@(posedge CLK) disable iff (SYS_RST)
		$onehot0(cks_ff);
	endproperty
	a_cksum_one: assert property (p_cksum_one) else $error("two checksum commands at once");

	property p_sleep_ignore;
		@(posedge CLK) disable iff (SYS_RST)
		(hit && DEEP_SLEEP) |=> (trap_ff == `ECCT_ADDR_RESET) && !flag_ff && (cnt16_ff == `ECCT_CNT_RESET);
	endproperty
	a_sleep_ignore: assert property (p_sleep_ignore) else $error("error taken in sleep");

	property p_esr_reserved;
		@(posedge CLK) disable iff (SYS_RST)
		(ERROR_STATUS_REGISTER[7:5] == 3'h0) && (ERROR_STATUS_REGISTER[3:0] == 4'h0);
	endproperty
	a_esr_reserved: assert property (p_esr_reserved) else $error("reserved status bit set");

	property p_flag_hold;
		@(posedge CLK) disable iff (SYS_RST)
		(flag_ff && !clear_evt && !DEEP_SLEEP) |=> flag_ff;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

	property p_idle_hold;
		@(posedge CLK) disable iff (SYS_RST)
		(!hit && !clear_evt && !DEEP_SLEEP) |=> $stable(trap_ff) && $stable(cnt16_ff) && $stable(flag_ff);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("record changed while idle");

	property p_query_addr;
		@(posedge CLK) disable iff (SYS_RST)
		ev_pulse[`ECCT_EV_QUERY] |=> (UNIT_QUERY_ADDR == $past(q_addr_ff)) && (UNIT_QUERY_ADDR[2:0] == 3'h0);
	endproperty
	a_query_addr: assert property (p_query_addr) else $error("query address wrong");

	property p_answer_hold;
		@(posedge CLK) disable iff (SYS_RST)
		UNIT_QUERY_REQ |=> $stable(UNIT_QUERY_ADDR);
	endproperty
	a_answer_hold: assert property (p_answer_hold) else $error("query address moved");

	property p_flag_count;
		@(posedge CLK) disable iff (SYS_RST)
		flag_ff |-> (cnt16_ff != `ECCT_CNT_RESET);
	endproperty
	a_flag_count: assert property (p_flag_count) else $error("flag without count");

	property p_dummy_bound;
		@(posedge SCK) disable iff (CS_N || SYS_RST)
		(phase_ff == ECCT_DUMMY) |-> (cnt_ff[3:0] < lat_s2_ff);
	endproperty
	a_dummy_bound: assert property (p_dummy_bound) else $error("too many dummy cycles");

	property p_data_bound;
		@(posedge SCK) disable iff (CS_N || SYS_RST)
		(phase_ff == ECCT_DATA) |-> (cnt_ff <= `ECCT_DATA_LAST);
	endproperty
	a_data_bound: assert property (p_data_bound) else $error("status byte too long");

	property p_done_quiet;
		@(posedge SCK) disable iff (CS_N || SYS_RST)
		(phase_ff == ECCT_DONE) |-> (nxt_ev_tgl == ev_tgl_ff) && !load_out;
	endproperty
	a_done_quiet: assert property (p_done_quiet) else $error("command after frame end");

endmodule

// File: verif/ecct_host.sv
// SPI host model issuing memory commands in mode 0
`timescale 1ns/1ps
module ecct_host
(
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// One 64 ns bit, data set while clock low
	task automatic bit_io(input logic b, output logic s);
	begin
		si = b;
		#16 sck = 1'b1;
		s = so;
		#32 sck = 1'b0;
		#16;
	end
	endtask
	// Whole frame: opcode, address, dummies, then data byte only when address bits are sent
	task automatic xfer(input logic [7:0] op, input logic [23:0] adr, input int na,
		input int nd, output logic [7:0] rd);
		logic s;
		int   i;
	begin
		rd = 8'h00;
		#3 cs_n = 1'b0;
		for (i = 7; i >= 0; i--)
			bit_io(op[i], s);
		for (i = na - 1; i >= 0; i--)
			bit_io(adr[i], s);
		for (i = 0; i < nd; i++)
			bit_io(~si, s);
		for (i = 7; i >= 0 && na > 0; i--)
		begin
			bit_io(~si, s);
			rd[i] = s;
		end
		#16 cs_n = 1'b1;
		si = ~si;
		#64;
	end
	endtask
endmodule

// File: verif/ecct_trap_bench.sv
// Self-checking bench of the error trap and command decode
`timescale 1ns/1ps
`include "ecct_params.svh"
module ecct_trap_bench
	import ecct_pkg::*;
;
	logic           clk;
	logic           sys_rst;
	logic           deep_sleep;
	logic           query_err;
	logic           ck_clr;
	logic [3:0]     lat;
	logic           sck;
	logic           cs_n;
	logic           si;
	logic           so;
	logic           so_oe;
	logic           query_req;
	logic [31:0]    trap;
	logic [15:0]    cnt;
	logic [7:0]     esr;
	logic [23:0]    qaddr;
	logic [7:0]     rd;
	logic [2:0]     ck_seen;
	ecct_err_type   ecc_err;
	ecct_cksum_type ck_cmd;
	int             num_errors;
	int             n_tests;
	int             n_req;

	ecct_trap u_ecct_trap (.CLK(clk), .SYS_RST(sys_rst), .ECC_ERR(ecc_err),
		.DEEP_SLEEP(deep_sleep), .MEMORY_LATENCY_FIELD(lat), .SCK(sck), .CS_N(cs_n),
		.SI(si), .SO(so), .SO_OE(so_oe), .FIRST_ERROR_UNIT_ADDRESS(trap),
		.ERROR_DETECT_COUNTER(cnt), .ERROR_STATUS_REGISTER(esr), .UNIT_QUERY_REQ(query_req),
		.UNIT_QUERY_ADDR(qaddr), .UNIT_QUERY_ERR(query_err), .CKSUM_CMD(ck_cmd));
	ecct_host u_ecct_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Collects checksum command pulses
	always @(posedge clk)
		ck_seen <= ck_clr ? 3'h0 : (ck_seen | ck_cmd);
	// Counts cycles with a unit query request
	always @(posedge clk)
		n_req <= sys_rst ? 0 : n_req + int'(query_req);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task automatic cyc(input int n);
	begin
		repeat (n) @(posedge clk);
	end
	endtask
	task automatic hit(input logic [23:0] a, input int n);
	begin
		@(posedge clk) ecc_err <= '{1'b1, a};
		cyc(n);
		ecc_err <= '{1'b0, 24'h000000};
		cyc(1);
	end
	endtask
	task automatic t_trap;
	begin
		check(trap, `ECCT_ADDR_RESET);
		check({cnt, esr}, 24'h000000);
		hit(24'h12345f, 1);
		check(trap, 32'h00123458);
		check(esr, 8'h10);
		hit(24'h0000a1, 2);
		check(trap, 32'h00123458);
		check(cnt, 16'h0003);
	end
	endtask
	task automatic t_status(input logic e, input logic [3:0] n, input logic [23:0] a,
		input logic [23:0] ua);
		int k;
	begin
		@(posedge clk) query_err <= e;
		lat <= n;
		k = n_req;
		u_ecct_host.xfer(`ECCT_OP_STATUS_READ, a, 24, n, rd);
		check(qaddr, ua);
		check(n_req, k + 1);
		check(rd, {4'h0, e, 3'h0});
		check(so_oe, 1'b0);
	end
	endtask
	task automatic t_clear;
	begin
		u_ecct_host.xfer(`ECCT_OP_CLEAR, 24'h000000, 0, 0, rd);
		cyc(8);
		check(trap, 32'h00000000);
		check({cnt, esr}, 24'h000000);
	end
	endtask
	task automatic t_cksum;
		logic [7:0] ops [3];
		int         i;
	begin
		ops = '{`ECCT_OP_CKSUM_RUN, `ECCT_OP_CKSUM_CONT, `ECCT_OP_CKSUM_PAUSE};
		for (i = 0; i < 3; i++)
		begin
			@(posedge clk) ck_clr <= 1'b1;
			@(posedge clk) ck_clr <= 1'b0;
			u_ecct_host.xfer(ops[i], 24'h000000, 0, 0, rd);
			cyc(8);
			check(ck_seen, 3'h1 << i);
		end
	end
	endtask
	task automatic t_sleep;
	begin
		hit(24'h00f010, 1);
		check(trap, 32'h0000f010);
		@(posedge clk) deep_sleep <= 1'b1;
		cyc(2);
		ecc_err <= '{1'b1, 24'h00f020};
		cyc(1);
		ecc_err <= '{1'b0, 24'h000000};
		deep_sleep <= 1'b0;
		cyc(1);
		check(trap, `ECCT_ADDR_RESET);
		check({cnt, esr}, 24'h000000);
	end
	endtask
	task automatic t_sat;
	begin
		hit(24'h000008, 65540);
		check(cnt, `ECCT_CNT_MAX);
		check(trap, 32'h00000008);
	end
	endtask
	task automatic print_verdict;
	begin
		$display("errors %0d comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask

	initial
	begin
		num_errors = 0;
		n_tests = 0;
		sys_rst = 1'b1;
		deep_sleep = 1'b0;
		query_err = 1'b0;
		ck_clr = 1'b1;
		lat = 4'h2;
		ecc_err = '{1'b0, 24'h000000};
		cyc(8);
		sys_rst <= 1'b0;
		ck_clr <= 1'b0;
		cyc(4);
		t_trap();
		t_status(1'b1, 4'h3, 24'h0abc2d, 24'h0abc28);
		t_status(1'b0, 4'h4, 24'h51f0f7, 24'h51f0f0);
		t_clear();
		t_cksum();
		t_sleep();
		t_sat();
		t_clear();
		print_verdict();
	end
	initial
	begin
		#700000;
		num_errors++;
		print_verdict();
	end
endmodule
